// [hw/dlim_defines.svh]
// Register offsets, field positions and reset values of the limit/mask bank.
// Assumes byte-wide registers behind an 8-bit address port.
`ifndef DLIM_DEFINES_SVH
`define DLIM_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define DLIM_OFF_CAL          8'h3C
`define DLIM_OFF_RANGE_LOW    8'h41
`define DLIM_OFF_RANGE_HIGH   8'h42
`define DLIM_OFF_IRQ_EN_LOW   8'h43
`define DLIM_OFF_REF_STATUS   8'h60
`define DLIM_OFF_CLAMP_STATUS 8'h61
`define DLIM_OFF_CLAMP_MASK   8'h62
`define DLIM_OFF_CLAMP_LIVE   8'h63

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DLIM_RST_CAL          8'h00
`define DLIM_RST_RANGE_LOW    8'h76
`define DLIM_RST_RANGE_HIGH   8'h00
`define DLIM_RST_IRQ_EN_LOW   8'h00
`define DLIM_RST_STATUS       8'h00
`define DLIM_RST_CLAMP_MASK   8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define DLIM_RANGE_HIGH_MSB   1
`define DLIM_RANGE_W          10
`define DLIM_CLAMP_MAIN_BIT   0
`define DLIM_CLAMP_AUX_BIT    1
`define DLIM_CLAMP_USED_MASK  8'h03

`endif

// [hw/dlim_pkg.sv]
// Types shared by the limit/mask bank, its port checker and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package dlim_pkg;

    typedef logic [7:0] dlim_byte_t;
    typedef logic [7:0] dlim_addr_t;

    typedef enum {
        DLIM_SEL_NONE,
        DLIM_SEL_CAL,
        DLIM_SEL_RANGE_LOW,
        DLIM_SEL_RANGE_HIGH,
        DLIM_SEL_IRQ_EN_LOW,
        DLIM_SEL_REF_STATUS,
        DLIM_SEL_CLAMP_STATUS,
        DLIM_SEL_CLAMP_MASK,
        DLIM_SEL_CLAMP_LIVE
    } dlim_sel_t;

endpackage

// [hw/dlim_clamp_if.sv]
// Link between the register bank and one clamp stage.
// Assumes both ends share one clock.
`timescale 1ns/10ps

interface dlim_clamp_if #(
    parameter int OFF_W = 24
);
    logic signed [OFF_W-1:0] offset;
    logic        [OFF_W-1:0] bound;
    logic signed [OFF_W-1:0] limited;
    logic                    hit;

    modport ctrl  (output offset, output bound, input  limited, input  hit);
    modport clamp (input  offset, input  bound, output limited, output hit);
endinterface

// [hw/dlim_clamp.sv]
// Symmetric clamp of a signed frequency offset to plus or minus a bound.
// Assumes the bound stays below half the signed range of the offset.
`timescale 1ns/10ps

module dlim_clamp #(
    parameter int OFF_W = 24
) (
    // Clock and reset
    input  wire logic   core_clk,
    input  wire logic   sys_rst,
    // Offset in, limited offset out
    dlim_clamp_if.clamp cif
);

    logic signed [OFF_W-1:0] pos_bound;
    logic signed [OFF_W-1:0] neg_bound;

    assign pos_bound = $signed(cif.bound);
    assign neg_bound = -$signed(cif.bound);

    // ------------------------------------------------------------------
    // Clamp register
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cif.limited <= '0;
            cif.hit     <= 1'b0;
        end else if (cif.offset > pos_bound) begin
            cif.limited <= pos_bound;
            cif.hit     <= 1'b1;
        end else if (cif.offset < neg_bound) begin
            cif.limited <= neg_bound;
            cif.hit     <= 1'b1;
        end else begin
            cif.limited <= cif.offset;
            cif.hit     <= 1'b0;
        end
    end

endmodule // dlim_clamp

// [hw/dlim_regs.sv]
// Pull-in limit and input interrupt enable bank with two offset clamps.
// Assumes a byte register port on core_clk; read data one cycle later.
//
// Functional notes
// - Limit is high[1:0] joined with low[7:0]
// - Limit bounds both main and aux loops
// - Low limit register resets to 0x76
// - Offsets corrected by oscillator calibration value
// - Enable bit n gates reference input n
// - Input enable register resets to zero
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
`include "dlim_defines.svh"

module dlim_regs #(
    parameter int OFF_W     = 24,
    parameter int STEP      = 1,
    parameter int CAL_SHIFT = 0
) (
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    sys_rst,
    // Register port
    input  wire dlim_pkg::dlim_addr_t    reg_addr,
    input  wire dlim_pkg::dlim_byte_t    reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output      dlim_pkg::dlim_byte_t    reg_rdata,
    // Raw offsets against the local crystal
    input  wire logic signed [OFF_W-1:0] main_freq_raw,
    input  wire logic signed [OFF_W-1:0] aux_freq_raw,
    // Reference input events
    input  wire logic [7:0]              ref_event,
    // Limited offsets
    output      logic signed [OFF_W-1:0] main_freq_lim,
    output      logic signed [OFF_W-1:0] aux_freq_lim,
    output      logic                    main_limit_hit,
    output      logic                    aux_limit_hit,
    // Limit value and interrupt
    output      logic [9:0]              pull_range_value,
    output      logic                    irq
);

    import dlim_pkg::*;

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    localparam longint MAX_BOUND = longint'(1023) * longint'(STEP);

    if (OFF_W < 12 || OFF_W > 48) begin : g_chk_off_w
        $error("OFF_W out of range");
    end

    if (STEP < 1) begin : g_chk_step
        $error("STEP must be at least one");
    end

    if (MAX_BOUND >= (longint'(1) <<< (OFF_W - 1))) begin : g_chk_bound
        $error("STEP too large for OFF_W");
    end

    if (CAL_SHIFT < 0 || CAL_SHIFT > OFF_W - 8) begin : g_chk_cal
        $error("CAL_SHIFT out of range");
    end

    if (`DLIM_RANGE_W != 10 || `DLIM_RANGE_HIGH_MSB != `DLIM_RANGE_W - 9) begin : g_chk_range
        $error("Limit field layout inconsistent");
    end

    if (`DLIM_CLAMP_MAIN_BIT > 1 || `DLIM_CLAMP_AUX_BIT > 1) begin : g_chk_hit_pos
        $error("Clamp status bit outside field");
    end

    if (`DLIM_CLAMP_MAIN_BIT == `DLIM_CLAMP_AUX_BIT) begin : g_chk_hit_dup
        $error("Clamp status bits overlap");
    end

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic dlim_sel_t decode(input dlim_addr_t addr);
        dlim_sel_t sel;
        sel = DLIM_SEL_NONE;
        unique case (addr)
            `DLIM_OFF_CAL:          sel = DLIM_SEL_CAL;
            `DLIM_OFF_RANGE_LOW:    sel = DLIM_SEL_RANGE_LOW;
            `DLIM_OFF_RANGE_HIGH:   sel = DLIM_SEL_RANGE_HIGH;
            `DLIM_OFF_IRQ_EN_LOW:   sel = DLIM_SEL_IRQ_EN_LOW;
            `DLIM_OFF_REF_STATUS:   sel = DLIM_SEL_REF_STATUS;
            `DLIM_OFF_CLAMP_STATUS: sel = DLIM_SEL_CLAMP_STATUS;
            `DLIM_OFF_CLAMP_MASK:   sel = DLIM_SEL_CLAMP_MASK;
            `DLIM_OFF_CLAMP_LIVE:   sel = DLIM_SEL_CLAMP_LIVE;
            default:                sel = DLIM_SEL_NONE;
        endcase
        return sel;
    endfunction

    dlim_sel_t wr_sel;
    dlim_sel_t rd_sel;

    assign wr_sel = reg_wr ? decode(reg_addr) : DLIM_SEL_NONE;
    assign rd_sel = reg_rd ? decode(reg_addr) : DLIM_SEL_NONE;

    // ------------------------------------------------------------------
    // Per-register write and read-clear strobes
    // ------------------------------------------------------------------
    logic wr_cal;
    logic wr_range_low;
    logic wr_range_high;
    logic wr_irq_en_low;
    logic wr_clamp_mask;
    logic clr_ref_status;
    logic clr_clamp_status;

    assign wr_cal           = (wr_sel == DLIM_SEL_CAL);
    assign wr_range_low     = (wr_sel == DLIM_SEL_RANGE_LOW);
    assign wr_range_high    = (wr_sel == DLIM_SEL_RANGE_HIGH);
    assign wr_irq_en_low    = (wr_sel == DLIM_SEL_IRQ_EN_LOW);
    assign wr_clamp_mask    = (wr_sel == DLIM_SEL_CLAMP_MASK);
    assign clr_ref_status   = (rd_sel == DLIM_SEL_REF_STATUS);
    assign clr_clamp_status = (rd_sel == DLIM_SEL_CLAMP_STATUS);

    // ------------------------------------------------------------------
    // Offset correction, shared by both paths
    // ------------------------------------------------------------------
    dlim_byte_t cal_q;

    function automatic logic signed [OFF_W-1:0] correct(
        input logic signed [OFF_W-1:0] raw,
        input dlim_byte_t              cal
    );
        logic signed [OFF_W-1:0] cal_ext;
        cal_ext = OFF_W'($signed(cal)) <<< CAL_SHIFT;
        return OFF_W'(raw + cal_ext);
    endfunction

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    dlim_byte_t range_low_q;
    logic [1:0] range_high_q;
    dlim_byte_t irq_en_low_q;
    dlim_byte_t clamp_mask_q;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cal_q <= `DLIM_RST_CAL;
        end else if (wr_cal) begin
            cal_q <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            range_low_q <= `DLIM_RST_RANGE_LOW;
        end else if (wr_range_low) begin
            range_low_q <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            range_high_q <= 2'(`DLIM_RST_RANGE_HIGH);
        end else if (wr_range_high) begin
            range_high_q <= reg_wdata[`DLIM_RANGE_HIGH_MSB:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irq_en_low_q <= `DLIM_RST_IRQ_EN_LOW;
        end else if (wr_irq_en_low) begin
            irq_en_low_q <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            clamp_mask_q <= `DLIM_RST_CLAMP_MASK;
        end else if (wr_clamp_mask) begin
            clamp_mask_q <= reg_wdata & `DLIM_CLAMP_USED_MASK;
        end
    end

    assign pull_range_value = {range_high_q, range_low_q};

    // ------------------------------------------------------------------
    // Bound and corrected offsets
    // ------------------------------------------------------------------
    logic [OFF_W-1:0]        bound_q;
    logic signed [OFF_W-1:0] main_corr_q;
    logic signed [OFF_W-1:0] aux_corr_q;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            bound_q <= '0;
        end else begin
            bound_q <= OFF_W'(OFF_W'(pull_range_value) * OFF_W'(STEP));
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            main_corr_q <= '0;
            aux_corr_q  <= '0;
        end else begin
            main_corr_q <= correct(main_freq_raw, cal_q);
            aux_corr_q  <= correct(aux_freq_raw, cal_q);
        end
    end

    // ------------------------------------------------------------------
    // Clamp stages, one per loop
    // ------------------------------------------------------------------
    dlim_clamp_if #(.OFF_W(OFF_W)) main_cif ();
    dlim_clamp_if #(.OFF_W(OFF_W)) aux_cif ();

    assign main_cif.offset = main_corr_q;
    assign main_cif.bound  = bound_q;
    assign aux_cif.offset  = aux_corr_q;
    assign aux_cif.bound   = bound_q;

    dlim_clamp #(
        .OFF_W (OFF_W)
    ) u_main_clamp (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .cif      (main_cif)
    );

    dlim_clamp #(
        .OFF_W (OFF_W)
    ) u_aux_clamp (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .cif      (aux_cif)
    );

    assign main_freq_lim  = main_cif.limited;
    assign aux_freq_lim   = aux_cif.limited;
    assign main_limit_hit = main_cif.hit;
    assign aux_limit_hit  = aux_cif.hit;

    // ------------------------------------------------------------------
    // Sticky event status
    // ------------------------------------------------------------------
    dlim_byte_t ref_status_q;
    logic [1:0] clamp_status_q;
    logic [1:0] hit_prev_q;
    logic [1:0] hit_rise;
    logic [1:0] hit_now;

    always_comb begin
        hit_now                       = 2'h0;
        hit_now[`DLIM_CLAMP_MAIN_BIT] = main_cif.hit;
        hit_now[`DLIM_CLAMP_AUX_BIT]  = aux_cif.hit;
    end

    assign hit_rise = hit_now & ~hit_prev_q;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            hit_prev_q <= 2'h0;
        end else begin
            hit_prev_q <= hit_now;
        end
    end

    // Set wins over read clear
    function automatic dlim_byte_t sticky_next(
        input dlim_byte_t old_bits,
        input dlim_byte_t set_bits,
        input logic       clear
    );
        return clear ? set_bits : (old_bits | set_bits);
    endfunction

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ref_status_q <= `DLIM_RST_STATUS;
        end else begin
            ref_status_q <= sticky_next(ref_status_q, ref_event, clr_ref_status);
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            clamp_status_q <= 2'h0;
        end else begin
            clamp_status_q <= 2'(sticky_next({6'h00, clamp_status_q}, {6'h00, hit_rise},
                                             clr_clamp_status));
        end
    end

    // ------------------------------------------------------------------
    // Interrupt output
    // ------------------------------------------------------------------
    logic irq_d;
    logic ref_pend;
    logic clamp_pend;

    // Bit n of the enable gates reference input n
    assign ref_pend   = |(ref_status_q & irq_en_low_q);
    assign clamp_pend = |(clamp_status_q & clamp_mask_q[1:0]);
    assign irq_d      = ref_pend | clamp_pend;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_d;
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    dlim_byte_t rdata_d;

    always_comb begin
        rdata_d = 8'h00;
        unique case (rd_sel)
            DLIM_SEL_NONE:         rdata_d = 8'h00;
            DLIM_SEL_CAL:          rdata_d = cal_q;
            DLIM_SEL_RANGE_LOW:    rdata_d = range_low_q;
            DLIM_SEL_RANGE_HIGH:   rdata_d = {6'h00, range_high_q};
            DLIM_SEL_IRQ_EN_LOW:   rdata_d = irq_en_low_q;
            DLIM_SEL_REF_STATUS:   rdata_d = ref_status_q;
            DLIM_SEL_CLAMP_STATUS: rdata_d = {6'h00, clamp_status_q};
            DLIM_SEL_CLAMP_MASK:   rdata_d = clamp_mask_q;
            DLIM_SEL_CLAMP_LIVE:   rdata_d = {6'h00, hit_now};
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= rdata_d;
        end
    end

endmodule // dlim_regs

// [bench/dlim_regs_sva.sv]
// Port-level checks of the limit/mask bank.
// Assumes one core_clk domain and a synchronous sys_rst.
`timescale 1ns/10ps
`include "dlim_defines.svh"

module dlim_regs_sva #(
    parameter int OFF_W = 24,
    parameter int STEP  = 1
) (
    // Clock and reset
    input wire logic                    core_clk,
    input wire logic                    sys_rst,
    // Register port
    input wire dlim_pkg::dlim_addr_t    reg_addr,
    input wire dlim_pkg::dlim_byte_t    reg_wdata,
    input wire logic                    reg_wr,
    input wire logic                    reg_rd,
    input wire dlim_pkg::dlim_byte_t    reg_rdata,
    // Offset path and status
    input wire logic signed [OFF_W-1:0] main_freq_lim,
    input wire logic signed [OFF_W-1:0] aux_freq_lim,
    input wire logic                    main_limit_hit,
    input wire logic                    aux_limit_hit,
    input wire logic [9:0]              pull_range_value,
    input wire logic                    irq
);
    import dlim_pkg::*;
    // ------------------------------------------------------------
    // Bound seen by the clamp, two edges late
    // ------------------------------------------------------------
    logic [9:0]              prv1_q;
    logic [9:0]              prv2_q;
    logic signed [OFF_W-1:0] bnd;
    always_ff @(posedge core_clk) begin
        prv1_q <= pull_range_value;
        prv2_q <= prv1_q;
    end
    assign bnd = OFF_W'(prv2_q * STEP);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_wr(a);
        reg_wr && reg_addr == a;
    endsequence
    sequence s_rd(a);
        reg_rd && reg_addr == a;
    endsequence

    a_low_write: assert property (
        s_wr(8'h41) |=> pull_range_value[7:0] == $past(reg_wdata)) else $error("low limit");
    a_high_write: assert property (
        s_wr(8'h42) |=> pull_range_value[9:8] == $past(reg_wdata[1:0])) else $error("high limit");
    a_high_unused: assert property (
        s_rd(8'h42) |=> reg_rdata[7:2] == 6'h00) else $error("high unused bits");
    a_limit_read: assert property (
        s_rd(8'h41) |=> reg_rdata == $past(pull_range_value[7:0])) else $error("low readback");
    a_en_readback: assert property (
        s_wr(8'h43) ##1 s_rd(8'h43) |=> reg_rdata == $past(reg_wdata, 2))
        else $error("enable readback");
    a_unmapped_rd: assert property (
        reg_rd && !(reg_addr inside {8'h3C, 8'h41, 8'h42, 8'h43, 8'h60, 8'h61, 8'h62, 8'h63})
        |=> reg_rdata == 8'h00) else $error("unmapped read");
    a_main_clamp: assert property (
        main_limit_hit |-> main_freq_lim == bnd || main_freq_lim == -bnd) else $error("main clamp");
    a_aux_clamp: assert property (
        aux_limit_hit |-> aux_freq_lim == bnd || aux_freq_lim == -bnd) else $error("aux clamp");
    a_irq_fall: assert property (
        $fell(irq) |-> $past(reg_rd, 2) || $past(reg_wr, 2)) else $error("irq fell alone");
endmodule // dlim_regs_sva

bind dlim_regs dlim_regs_sva #(.OFF_W(OFF_W), .STEP(STEP)) i_dlim_regs_sva (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .main_freq_lim(main_freq_lim),
    .aux_freq_lim(aux_freq_lim), .main_limit_hit(main_limit_hit),
    .aux_limit_hit(aux_limit_hit), .pull_range_value(pull_range_value), .irq(irq));

// [bench/tb.sv]
// Directed bench for the limit/mask bank.
// Assumes the port checker is bound from its own file.
`timescale 1ns/10ps

`define CHK(act, exp) begin checked++; if ((act) !== (exp)) begin bad_count++; \
    $display("[ERR] t=%0t got %h exp %h", $time, (act), (exp)); end end

module tb;
    import dlim_pkg::*;
    localparam int OFF_W = 24;
    logic                    core_clk;
    logic                    sys_rst;
    dlim_addr_t              reg_addr;
    dlim_byte_t              reg_wdata;
    dlim_byte_t              reg_rdata;
    logic                    reg_wr;
    logic                    reg_rd;
    logic signed [OFF_W-1:0] main_freq_raw;
    logic signed [OFF_W-1:0] aux_freq_raw;
    logic signed [OFF_W-1:0] main_freq_lim;
    logic signed [OFF_W-1:0] aux_freq_lim;
    logic [7:0]              ref_event;
    logic                    main_limit_hit;
    logic                    aux_limit_hit;
    logic [9:0]              pull_range_value;
    logic                    irq;
    int                      bad_count;
    int                      checked;

    dlim_regs #(.OFF_W(OFF_W), .STEP(1), .CAL_SHIFT(0)) i_dlim_regs (
        .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .main_freq_raw(main_freq_raw), .aux_freq_raw(aux_freq_raw), .ref_event(ref_event),
        .main_freq_lim(main_freq_lim), .aux_freq_lim(aux_freq_lim),
        .main_limit_hit(main_limit_hit), .aux_limit_hit(aux_limit_hit),
        .pull_range_value(pull_range_value), .irq(irq));

    // ------------------------------------------------------------
    // Bus and stimulus helpers
    // ------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input dlim_addr_t a, input dlim_byte_t d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input dlim_addr_t a, input dlim_byte_t e);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask
    task automatic wr_rd(input dlim_addr_t a, input dlim_byte_t d, input dlim_byte_t e);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask
    task automatic drv(input int m, input int a);
        @(posedge core_clk);
        main_freq_raw <= OFF_W'(m);
        aux_freq_raw <= OFF_W'(a);
        cyc(2);
    endtask
    task automatic pulse(input logic [7:0] e);
        @(posedge core_clk);
        ref_event <= e;
        @(posedge core_clk);
        ref_event <= 8'h00;
        cyc(1);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        cyc(1);
        `CHK(pull_range_value, 10'h076)
        rd_chk(8'h41, 8'h76);
        rd_chk(8'h42, 8'h00);
        rd_chk(8'h43, 8'h00);
        `CHK(irq, 1'b0)
    endtask
    task automatic t_limit;
        wr_rd(8'h42, 8'hFF, 8'h03);
        wr_rd(8'h41, 8'h05, 8'h05);
        `CHK(pull_range_value, 10'h305)
        wr(8'h50, 8'h12);
        rd_chk(8'h50, 8'h00);
    endtask
    task automatic t_clamp;
        drv(1000, -1000);
        `CHK(main_freq_lim, 24'sd773)
        `CHK(aux_freq_lim, -24'sd773)
        `CHK({main_limit_hit, aux_limit_hit}, 2'b11)
        drv(773, -773);
        `CHK({main_limit_hit, aux_limit_hit}, 2'b00)
        `CHK(aux_freq_lim, -24'sd773)
        wr(8'h3C, 8'h10);
        drv(100, -5);
        `CHK(main_freq_lim, 24'sd116)
        `CHK(aux_freq_lim, 24'sd11)
        wr(8'h3C, 8'hF0);
        drv(100, 0);
        `CHK(main_freq_lim, 24'sd84)
        `CHK(aux_freq_lim, -24'sd16)
        wr(8'h3C, 8'h00);
        wr(8'h42, 8'h00);
        wr(8'h41, 8'h00);
        drv(1000, -1);
        `CHK(main_freq_lim, 24'sd0)
        `CHK(aux_freq_lim, 24'sd0)
        rd_chk(8'h63, 8'h03);
        rd_chk(8'h61, 8'h03);
        rd_chk(8'h61, 8'h00);
        wr_rd(8'h62, 8'hFF, 8'h03);
        drv(0, 0);
        `CHK({main_limit_hit, aux_limit_hit}, 2'b00)
        drv(1000, -1000);
        cyc(2);
        `CHK(irq, 1'b1)
        rd_chk(8'h61, 8'h03);
        cyc(1);
        `CHK(irq, 1'b0)
    endtask
    task automatic t_irq;
        for (int n = 0; n < 8; n++) begin
            wr_rd(8'h43, 8'h01 << n, 8'h01 << n);
            pulse(~(8'h01 << n));
            `CHK(irq, 1'b0)
            pulse(8'h01 << n);
            `CHK(irq, 1'b1)
            rd_chk(8'h60, 8'hFF);
            cyc(1);
            `CHK(irq, 1'b0)
        end
    endtask

    task automatic t_rerst;
        wr(8'h41, 8'h11);
        pulse(8'h80);
        `CHK(irq, 1'b1)
        @(posedge core_clk);
        sys_rst <= 1'b1;
        cyc(2);
        `CHK(irq, 1'b0)
        `CHK(pull_range_value, 10'h076)
        `CHK({main_limit_hit, aux_limit_hit}, 2'b00)
        @(posedge core_clk);
        sys_rst <= 1'b0;
        rd_chk(8'h43, 8'h00);
        rd_chk(8'h41, 8'h76);
    endtask

    task automatic stop_test;
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        stop_test();
    end
    initial begin
        bad_count = 0;
        checked = 0;
        sys_rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        main_freq_raw = '0;
        aux_freq_raw = '0;
        ref_event = 8'h00;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_limit();
        t_clamp();
        t_irq();
        t_rerst();
        stop_test();
    end
endmodule // tb
